/* File: sim/loop_test_checker.sv */
// Concurrent checks on the ports of the loop test block
`timescale 1ns/10ps
`default_nettype none
module loop_test_checker #(
	parameter int REMOTE_CYCLES = 100,
	parameter int SECOND_CYCLES = 10,
	parameter int FIFO_DEPTH = 32
) (
	// Watched ports
	input wire logic clock,
	input wire logic reset,
	input wire loop_test_pkg::command_s cmd,
	input wire logic clear_error_count,
	input wire logic other_if_loop,
	input wire logic channel_loop,
	input wire logic bit_en,
	input wire logic line_rx,
	input wire logic line_tx,
	input wire logic device_tx,
	input wire logic device_rx,
	input wire logic network_msg_en,
	input wire logic link_disturbed,
	input wire loop_test_pkg::active_s active,
	input wire logic conflict,
	input wire logic [31:0] error_count
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	logic loops, busy, blocked;
	logic [31:0] rem_cnt_ff;
	always_comb begin
		loops = active.line_loop | active.payload_loop | active.repeater_loop;
		busy = active.pattern_send | active.remote_send | channel_loop;
		case (cmd.test)
		loop_test_pkg::cmd_line: blocked = busy | active.payload_loop;
		loop_test_pkg::cmd_payload: blocked = busy | active.line_loop
			| active.repeater_loop;
		loop_test_pkg::cmd_repeater: blocked = busy | active.payload_loop
			| other_if_loop;
		loop_test_pkg::cmd_remote, loop_test_pkg::cmd_send: blocked = busy | loops;
		default: blocked = 1'b0;
		endcase
	end
	// Cycles the remote code has been sent
	always_ff @(posedge clock) begin
		if (reset || !active.remote_send) begin
			rem_cnt_ff <= 32'h0;
		end else begin
			rem_cnt_ff <= rem_cnt_ff + 32'h1;
		end
	end
	sequence loop_held;
		loops && $past(loops);
	endsequence
	sequence rep_held;
		active.repeater_loop && $past(active.repeater_loop);
	endsequence
	sequence rep_bit;
		active.repeater_loop && $past(active.repeater_loop) && $past(bit_en);
	endsequence
	line_echo_a: assert property (active.line_loop && bit_en && !cmd.stop
		|=> line_tx == $past(line_rx)) else $error("line echo wrong");
	rep_feed_a: assert property (rep_bit |-> device_rx == $past(device_tx))
		else $error("repeater feed wrong");
	msg_block_a: assert property (rep_held |-> !network_msg_en)
		else $error("network messages not ignored");
	start_refuse_a: assert property (cmd.start && blocked
		|=> conflict && active[5:2] == $past(active[5:2]))
		else $error("conflicting start accepted");
	start_accept_a: assert property (cmd.start && !blocked
		&& cmd.test == loop_test_pkg::cmd_line |=> active.line_loop && !conflict)
		else $error("line loop start lost");
	stop_payload_a: assert property (cmd.stop && !cmd.start
		&& cmd.test == loop_test_pkg::cmd_payload |=> !active.payload_loop)
		else $error("payload loop not stopped");
	remote_len_a: assert property (rem_cnt_ff <= REMOTE_CYCLES + 1)
		else $error("remote code sent too long");
	clear_count_a: assert property (clear_error_count && active.monitor
		&& !cmd.stop |=> error_count <= 32'h1 && active.monitor)
		else $error("error count clear wrong");
	link_flag_a: assert property (loop_held |-> link_disturbed)
		else $error("link disturb flag missing");
endmodule
bind loop_test loop_test_checker #(.REMOTE_CYCLES(REMOTE_CYCLES),
	.SECOND_CYCLES(SECOND_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (
	.clock(clock), .reset(reset), .cmd(cmd),
	.clear_error_count(clear_error_count), .other_if_loop(other_if_loop),
	.channel_loop(channel_loop), .bit_en(bit_en), .line_rx(line_rx),
	.line_tx(line_tx), .device_tx(device_tx), .device_rx(device_rx),
	.network_msg_en(network_msg_en), .link_disturbed(link_disturbed),
	.active(active), .conflict(conflict), .error_count(error_count));
`default_nettype wire

/* File: sim/loop_test_tb_top.sv */
// Bench for the loop test block
`timescale 1ns/10ps
`default_nettype none
module loop_test_tb_top;
	logic clock = 1'b0;
	logic reset = 1'b1;
	loop_test_pkg::command_s cmd = '0;
	logic inject_error = 1'b0;
	logic clear_error_count = 1'b0;
	logic other_if_loop = 1'b0;
	logic channel_loop = 1'b0;
	logic rx_bit = 1'b1;
	logic stall = 1'b0;
	logic bit_en, line_rx, line_tx, framer_rx, device_tx, framer_tx_valid;
	logic framer_tx_ready, framer_tx, device_rx, network_msg_en;
	logic link_disturbed, conflict;
	loop_test_pkg::active_s active;
	logic [31:0] error_count;
	logic [15:0] elapsed_s, w1, w2;
	int error_cnt = 0;
	int samples_checked = 0;
	int n, pops;
	loop_test_pkg::test_e refused[3] = '{loop_test_pkg::cmd_payload,
		loop_test_pkg::cmd_send, loop_test_pkg::cmd_remote};
	loop_test_pkg::pattern_e pats[3] = '{loop_test_pkg::pat_zeros,
		loop_test_pkg::pat_ones, loop_test_pkg::pat_1in8};
	int ones[3] = '{0, 16, 2};
	always #10 clock = !clock;
	always @(posedge clock) if (framer_tx_valid && framer_tx_ready) pops++;
	t1_facility_model i_far (.clock(clock), .rx_bit(rx_bit), .stall(stall),
		.bit_en(bit_en), .line_rx(line_rx), .framer_rx(framer_rx),
		.device_tx(device_tx), .framer_tx_ready(framer_tx_ready));
	loop_test #(.REMOTE_CYCLES(200), .SECOND_CYCLES(10)) i_dut (
		.clock(clock), .reset(reset), .cmd(cmd), .inject_error(inject_error),
		.clear_error_count(clear_error_count), .other_if_loop(other_if_loop),
		.channel_loop(channel_loop), .bit_en(bit_en), .line_rx(line_rx),
		.line_tx(line_tx), .framer_rx(framer_rx), .device_tx(device_tx),
		.framer_tx_valid(framer_tx_valid), .framer_tx_ready(framer_tx_ready),
		.framer_tx(framer_tx), .device_rx(device_rx),
		.network_msg_en(network_msg_en), .link_disturbed(link_disturbed),
		.active(active), .conflict(conflict), .error_count(error_count),
		.elapsed_s(elapsed_s));
	task automatic check(logic [31:0] seen, logic [31:0] exp, string msg);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask
	task automatic give_verdict;
		if (error_cnt == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic order(logic s, loop_test_pkg::test_e t);
		@(negedge clock);
		cmd.start = s;
		cmd.stop = !s;
		cmd.test = t;
		@(negedge clock);
		cmd.start = 1'b0;
		cmd.stop = 1'b0;
	endtask
	task automatic get_bits(int cnt, output logic [15:0] w);
		int got;
		got = 0;
		for (int i = 0; i < 400 && got < cnt; i++) begin
			@(negedge clock);
			if (bit_en) begin
				w = {w[14:0], line_tx};
				got++;
			end
		end
		if (got < cnt) begin
			check(32'h0, 32'h1, "bit timeout");
			give_verdict();
		end
	endtask
	initial begin
		repeat (3) @(negedge clock);
		reset = 1'b0;
		check({active, conflict}, 7'h00, "reset state");
		check({network_msg_en, framer_tx_valid}, 2'h2, "reset outputs");
		order(1, loop_test_pkg::cmd_line);
		@(negedge clock);
		check({active, link_disturbed}, 7'h41, "line loop on");
		get_bits(16, w1);
		check(w1, 16'hFFFF, "line echo");
		foreach (refused[i]) begin
			order(1, refused[i]);
			check({conflict, active}, 7'h60, "start refused");
		end
		order(0, loop_test_pkg::cmd_line);
		check({conflict, active}, 7'h00, "line loop off");
		other_if_loop = 1'b1;
		order(1, loop_test_pkg::cmd_repeater);
		check({conflict, active}, 7'h40, "repeater refused");
		other_if_loop = 1'b0;
		order(1, loop_test_pkg::cmd_repeater);
		repeat (2) @(negedge clock);
		check(network_msg_en, 1'b0, "messages ignored");
		get_bits(1, w1);
		check(device_rx, device_tx, "repeater feed");
		order(1, loop_test_pkg::cmd_payload);
		check({conflict, active}, 7'h48, "payload refused");
		order(0, loop_test_pkg::cmd_repeater);
		cmd.pattern = loop_test_pkg::pat_user;
		cmd.user_word = 16'hA5C3;
		order(1, loop_test_pkg::cmd_send);
		get_bits(16, w1);
		get_bits(16, w2);
		n = 0;
		for (int k = 0; k < 16; k++) n += int'(16'({w1, w1} >> k) == 16'hA5C3);
		check(n, 1, "user word sent");
		check(w2, w1, "user word repeats");
		order(1, loop_test_pkg::cmd_line);
		check({conflict, active}, 7'h44, "line refused");
		inject_error = 1'b1;
		@(negedge clock);
		inject_error = 1'b0;
		get_bits(16, w2);
		check($countones(w1 ^ w2), 1, "one bit flipped");
		order(0, loop_test_pkg::cmd_send);
		foreach (pats[i]) begin
			cmd.pattern = pats[i];
			order(1, loop_test_pkg::cmd_send);
			get_bits(16, w1);
			check($countones(w1), ones[i], "pattern density");
			order(0, loop_test_pkg::cmd_send);
		end
		cmd.pattern = loop_test_pkg::pat_ones;
		order(1, loop_test_pkg::cmd_monitor);
		repeat (40) @(negedge clock);
		check(error_count, 32'h0, "no errors");
		rx_bit <= 1'b0;
		repeat (40) @(negedge clock);
		rx_bit <= 1'b1;
		check(error_count != 0, 1'b1, "errors counted");
		repeat (8) @(negedge clock);
		clear_error_count = 1'b1;
		@(negedge clock);
		clear_error_count = 1'b0;
		repeat (8) @(negedge clock);
		check({error_count, active.monitor}, 33'h1, "count cleared");
		order(0, loop_test_pkg::cmd_monitor);
		channel_loop = 1'b1;
		order(1, loop_test_pkg::cmd_remote);
		check({conflict, active}, 7'h40, "remote refused");
		channel_loop = 1'b0;
		cmd.remote_up = 1'b1;
		order(1, loop_test_pkg::cmd_remote);
		repeat (35) @(negedge clock);
		check(elapsed_s, 16'h3, "elapsed seconds");
		get_bits(10, w1);
		check($countones(w1[9:0]), 2, "up code");
		repeat (100) @(negedge clock);
		check(active.remote_send, 1'b1, "code still sent");
		repeat (40) @(negedge clock);
		check(active.remote_send, 1'b0, "code stopped");
		cmd.remote_up = 1'b0;
		order(1, loop_test_pkg::cmd_remote);
		get_bits(9, w1);
		check($countones(w1[8:0]), 3, "down code");
		order(0, loop_test_pkg::cmd_remote);
		stall <= 1'b1;
		order(1, loop_test_pkg::cmd_payload);
		repeat (160) @(negedge clock);
		check({framer_tx_valid, framer_tx}, 2'h3, "loop data held");
		order(0, loop_test_pkg::cmd_payload);
		pops = 0;
		stall <= 1'b0;
		repeat (100) @(negedge clock);
		check({framer_tx_valid, pops[7:0]}, 9'h020, "fifo drained");
		give_verdict();
	end
endmodule
`default_nettype wire

/* File: sim/t1_facility_model.sv */
// Facility side model: bit timing, received bits, drain stalls
`timescale 1ns/10ps
`default_nettype none
module t1_facility_model (
	// Clock and control
	input wire logic clock,
	input wire logic rx_bit,
	input wire logic stall,
	// Toward the block
	output logic bit_en,
	output logic line_rx,
	output logic framer_rx,
	output logic device_tx,
	output logic framer_tx_ready
);
	logic [1:0] phase_ff = 2'h0;
	initial begin
		{bit_en, line_rx, framer_rx, device_tx, framer_tx_ready} = 5'h01;
	end
	// Bit valid only on its strobe; inverted between strobes
	always @(negedge clock) begin
		phase_ff <= phase_ff + 2'h1;
		bit_en <= (phase_ff == 2'h3);
		line_rx <= (phase_ff == 2'h3) ? rx_bit : !rx_bit;
		framer_rx <= (phase_ff == 2'h3) ? rx_bit : !rx_bit;
		device_tx <= !device_tx;
		framer_tx_ready <= !stall;
	end
endmodule
`default_nettype wire

/* File: verilog/bit_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module bit_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0] cnt_ff;
	logic push;
	logic pop;
	assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid = (cnt_ff != '0);
	assign out_data = mem[rd_ff];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ff] <= in_data;
		end
		if (reset) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
			end
			if (pop) begin
				rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
			end
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

/* File: verilog/loop_test.sv */
// T1 interface loopbacks, remote loop codes and pattern send/check
`timescale 1ns/10ps
`default_nettype none
`include "loop_test_defs.svh"
// What this block does
// R01 - Line loop returns received line bits straight back to the line.
// R02 - Payload loop sends received framed data back through the framers.
// R03 - Repeater loop feeds the whole outgoing stream back into receive.
// R04 - Repeater loop ignores every message arriving from the network.
// R05 - Line loop refused if payload, send, remote or channel loop runs.
// R06 - Payload loop refused if line, repeater, send, remote or channel loop.
// R07 - Repeater loop refused on payload loop, other-interface loop, send, remote.
// R08 - Remote code refused while any loop, send, remote or channel loop runs.
// R09 - Transmits in-band up or down loop codes for the remote unit.
// R10 - A remote code is sent continuously for ten seconds, then stops.
// R11 - Pattern send or check: QRSS, zeros, ones, 1-in-8, 3-in-24, PRBS, user.
// R12 - User pattern is a programmable 16-bit word, repeated.
// R13 - An error-insert command flips one bit of the sent pattern; one that comes with bit_en is lost, several between bits flip one bit.
// R14 - Monitor counts bit errors; clear command zeroes the count only.
// R15 - Each active test keeps a readable elapsed seconds count; the block keeps one shared count, restarted by any accepted start.
// R16 - Pattern send refused while any loop, send, remote or channel loop.
// R17 - Loopbacks start and stop by command and report active state.
// R18 - Loopbacks may disturb the data links; their traffic is not kept.
// R19 - A conflicting start is rejected, tests unchanged, conflict flagged.
module loop_test #(
	parameter int REMOTE_CYCLES = `REMOTE_CODE_CYCLES,
	parameter int SECOND_CYCLES = `SECOND_CYCLES,
	parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Management commands
	input wire loop_test_pkg::command_s cmd,
	input wire logic inject_error,
	input wire logic clear_error_count,
	input wire logic other_if_loop,
	input wire logic channel_loop,
	// Line side, one bit per enable
	input wire logic bit_en,
	input wire logic line_rx,
	output logic line_tx,
	// Framer side
	input wire logic framer_rx,
	input wire logic device_tx,
	output logic framer_tx_valid,
	input wire logic framer_tx_ready,
	output logic framer_tx,
	output logic device_rx,
	output logic network_msg_en,
	output logic link_disturbed,
	// Status
	output loop_test_pkg::active_s active,
	output logic conflict,
	output logic [31:0] error_count,
	output logic [15:0] elapsed_s
);
	typedef struct packed {
		loop_test_pkg::active_s act;
		logic conflict;
		logic remote_up;
		logic [31:0] remote_cnt;
		logic [4:0] code_sh;
		loop_test_pkg::pattern_e pattern;
		logic [15:0] user_word;
		logic [22:0] gen;
		logic [22:0] chk;
		logic [4:0] phase;
		logic inject_pend;
		logic [31:0] errors;
		logic [31:0] sec_cnt;
		logic [15:0] elapsed;
		logic line_tx;
		logic device_rx;
		logic net_msg;
		logic link_dist;
	} state_s;

	state_s st_ff;
	state_s nxt_st;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_data;
	logic fifo_in_valid;

	// Received framed data is queued toward the transmit framer
	assign fifo_in_valid = bit_en && st_ff.act.payload_loop; // see R02
	bit_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock(clock),
		.reset(reset),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(framer_rx),
		.out_valid(fifo_out_valid),
		.out_ready(framer_tx_ready),
		.out_data(fifo_out_data)
	);
	assign framer_tx_valid = fifo_out_valid;
	assign framer_tx = fifo_out_data;

	// Next pattern bit for a register and pattern choice
	function automatic logic pat_bit(input loop_test_pkg::pattern_e p,
			input logic [22:0] r, input logic [4:0] ph,
			input logic [15:0] uw);
		logic b;
		b = 1'b0;
		case (p)
			loop_test_pkg::pat_qrss: b = r[19] ^ r[16];
			loop_test_pkg::pat_zeros: b = 1'b0;
			loop_test_pkg::pat_ones: b = 1'b1;
			loop_test_pkg::pat_1in8: b = (ph[2:0] == 3'h0);
			loop_test_pkg::pat_3in24: b = (ph == 5'h0) || (ph == 5'h4) ||
				(ph == 5'h17);
			loop_test_pkg::pat_prbs63: b = r[5] ^ r[4];
			loop_test_pkg::pat_prbs511: b = r[8] ^ r[4];
			loop_test_pkg::pat_prbs2047: b = r[10] ^ r[8];
			loop_test_pkg::pat_prbs15: b = r[14] ^ r[13];
			loop_test_pkg::pat_prbs20: b = r[19] ^ r[2];
			loop_test_pkg::pat_user: b = uw[4'hF - ph[3:0]];
			default: b = 1'b0;
		endcase
		return b;
	endfunction

	// Shift a pattern bit into a generator register, avoiding lockup at zero
	function automatic logic [22:0] pat_shift(input logic [22:0] r,
			input logic b);
		logic [22:0] n;
		n = {r[21:0], b};
		if (n == 23'h0) begin
			n = 23'h1;
		end
		return n;
	endfunction

	logic allowed;
	logic any_loop;
	logic busy_common;
	logic gen_bit;
	logic chk_bit;
	logic [4:0] ph_next;

	always_comb begin
		nxt_st = st_ff;
		any_loop = st_ff.act.line_loop || st_ff.act.payload_loop ||
			st_ff.act.repeater_loop;
		busy_common = st_ff.act.pattern_send || st_ff.act.remote_send ||
			channel_loop;
		allowed = 1'b0;
		case (cmd.test)
			loop_test_pkg::cmd_line:
				allowed = !st_ff.act.payload_loop && !busy_common; // see R05
			loop_test_pkg::cmd_payload:
				allowed = !st_ff.act.line_loop && // see R06
					!st_ff.act.repeater_loop && !busy_common;
			loop_test_pkg::cmd_repeater:
				allowed = !st_ff.act.payload_loop && // see R07
					!other_if_loop && !busy_common;
			loop_test_pkg::cmd_remote:
				allowed = !any_loop && !busy_common; // see R08
			loop_test_pkg::cmd_send:
				allowed = !any_loop && !busy_common; // see R16
			loop_test_pkg::cmd_monitor: allowed = 1'b1;
			default: allowed = 1'b0;
		endcase
		// Start and stop commands; conflicts leave tests alone
		if (cmd.start) begin
			nxt_st.conflict = !allowed; // see R19
			if (allowed) begin // see R17
				nxt_st.sec_cnt = '0;
				nxt_st.elapsed = '0;
				case (cmd.test)
					loop_test_pkg::cmd_line: nxt_st.act.line_loop = 1'b1;
					loop_test_pkg::cmd_payload: nxt_st.act.payload_loop = 1'b1;
					loop_test_pkg::cmd_repeater: nxt_st.act.repeater_loop = 1'b1;
					loop_test_pkg::cmd_remote: begin
						nxt_st.act.remote_send = 1'b1;
						nxt_st.remote_up = cmd.remote_up;
						nxt_st.remote_cnt = '0;
						nxt_st.code_sh = '0;
					end
					loop_test_pkg::cmd_send, loop_test_pkg::cmd_monitor: begin
						nxt_st.pattern = cmd.pattern; // see R11
						nxt_st.user_word = cmd.user_word; // see R12
						nxt_st.phase = '0;
						if (cmd.test == loop_test_pkg::cmd_send) begin
							nxt_st.act.pattern_send = 1'b1;
						end else begin
							nxt_st.act.monitor = 1'b1;
							nxt_st.errors = '0;
						end
					end
					default: nxt_st.conflict = 1'b0;
				endcase
			end
		end else if (cmd.stop) begin // see R17
			nxt_st.conflict = 1'b0;
			case (cmd.test)
				loop_test_pkg::cmd_line: nxt_st.act.line_loop = 1'b0;
				loop_test_pkg::cmd_payload: nxt_st.act.payload_loop = 1'b0;
				loop_test_pkg::cmd_repeater: nxt_st.act.repeater_loop = 1'b0;
				loop_test_pkg::cmd_remote: nxt_st.act.remote_send = 1'b0;
				loop_test_pkg::cmd_send: nxt_st.act.pattern_send = 1'b0;
				loop_test_pkg::cmd_monitor: nxt_st.act.monitor = 1'b0;
				default: nxt_st.conflict = 1'b0;
			endcase
		end
		// Elapsed seconds for whichever tests run
		if (st_ff.act != '0 && !(cmd.start && allowed)) begin // see R15
			if (st_ff.sec_cnt == 32'(SECOND_CYCLES - 1)) begin
				nxt_st.sec_cnt = '0;
				nxt_st.elapsed = st_ff.elapsed + 16'h1;
			end else begin
				nxt_st.sec_cnt = st_ff.sec_cnt + 32'h1;
			end
		end
		// Remote code time limit
		if (st_ff.act.remote_send) begin // see R10
			if (st_ff.remote_cnt == 32'(REMOTE_CYCLES - 1)) begin
				nxt_st.act.remote_send = 1'b0;
			end else begin
				nxt_st.remote_cnt = st_ff.remote_cnt + 32'h1;
			end
		end
		if (inject_error && st_ff.act.pattern_send) begin
			nxt_st.inject_pend = 1'b1;
		end
		// Error count clear; a new error in the same cycle still counts
		if (clear_error_count) begin // see R14
			nxt_st.errors = '0;
		end
		// User word repeats every 16 bits, fixed patterns every 24
		ph_next = ((st_ff.phase == 5'h17) ||
			((st_ff.pattern == loop_test_pkg::pat_user) &&
			(st_ff.phase == 5'h0F))) ? 5'h0 : st_ff.phase + 5'h1; // see R12
		gen_bit = pat_bit(st_ff.pattern, st_ff.gen, st_ff.phase,
			st_ff.user_word);
		chk_bit = pat_bit(st_ff.pattern, st_ff.chk, st_ff.phase,
			st_ff.user_word);
		nxt_st.net_msg = !st_ff.act.repeater_loop; // see R04
		nxt_st.link_dist = any_loop; // see R18
		if (bit_en) begin
			nxt_st.device_rx = st_ff.act.repeater_loop ? device_tx : // see R03
				framer_rx;
			if (st_ff.act.pattern_send || st_ff.act.monitor) begin
				nxt_st.phase = ph_next;
			end
			if (st_ff.act.line_loop) begin
				nxt_st.line_tx = line_rx; // see R01
			end else if (st_ff.act.remote_send) begin
				// Up and down codes repeat by their own period
				nxt_st.line_tx = st_ff.remote_up ? // see R09
					(st_ff.code_sh == 5'h0) : (st_ff.code_sh[1:0] == 2'h0);
				nxt_st.code_sh = st_ff.remote_up ?
					((st_ff.code_sh == 5'h4) ? 5'h0 : st_ff.code_sh + 5'h1) :
					((st_ff.code_sh == 5'h2) ? 5'h0 : st_ff.code_sh + 5'h1);
			end else if (st_ff.act.pattern_send) begin
				nxt_st.line_tx = gen_bit ^ st_ff.inject_pend; // see R13
				nxt_st.inject_pend = 1'b0;
				nxt_st.gen = pat_shift(st_ff.gen, gen_bit);
			end else begin
				nxt_st.line_tx = device_tx;
			end
			if (st_ff.act.monitor) begin
				// Checker reseeds itself from the received bits
				nxt_st.chk = pat_shift(st_ff.chk, line_rx);
				if (line_rx != chk_bit) begin // see R14
					nxt_st.errors = nxt_st.errors + 32'h1;
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			st_ff <= '0;
			st_ff.gen <= 23'h1;
			st_ff.chk <= 23'h1;
			st_ff.user_word <= `USER_WORD_RESET;
			st_ff.net_msg <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign line_tx = st_ff.line_tx;
	assign device_rx = st_ff.device_rx;
	assign network_msg_en = st_ff.net_msg;
	assign link_disturbed = st_ff.link_dist;
	assign active = st_ff.act;
	assign conflict = st_ff.conflict;
	assign error_count = st_ff.errors;
	assign elapsed_s = st_ff.elapsed;
endmodule
`default_nettype wire

/* File: verilog/loop_test_defs.svh */
// Constants for the T1 loopback and pattern test block
`ifndef LOOP_TEST_DEFS_SVH
`define LOOP_TEST_DEFS_SVH
`define CLK_HZ 50000000
`define REMOTE_CODE_SECONDS 10
`define REMOTE_CODE_CYCLES (`REMOTE_CODE_SECONDS * `CLK_HZ)
`define SECOND_CYCLES `CLK_HZ
`define UP_CODE 5'h10
`define DOWN_CODE 3'h4
`define USER_WORD_RESET 16'h0000
`define FIFO_DEPTH 32
`endif

/* File: verilog/loop_test_pkg.sv */
// Types for the T1 loopback and pattern test block
package loop_test_pkg;
	typedef enum logic [3:0] {
		pat_qrss = 4'h0,
		pat_zeros = 4'h1,
		pat_ones = 4'h2,
		pat_1in8 = 4'h3,
		pat_3in24 = 4'h4,
		pat_prbs63 = 4'h5,
		pat_prbs511 = 4'h6,
		pat_prbs2047 = 4'h7,
		pat_prbs15 = 4'h8,
		pat_prbs20 = 4'h9,
		pat_user = 4'hA
	} pattern_e;
	typedef enum logic [2:0] {
		cmd_none = 3'h0,
		cmd_line = 3'h1,
		cmd_payload = 3'h2,
		cmd_repeater = 3'h3,
		cmd_send = 3'h4,
		cmd_remote = 3'h5,
		cmd_monitor = 3'h6
	} test_e;
	typedef struct packed {
		logic line_loop;
		logic payload_loop;
		logic repeater_loop;
		logic pattern_send;
		logic remote_send;
		logic monitor;
	} active_s;
	typedef struct packed {
		logic start;
		logic stop;
		test_e test;
		logic remote_up;
		pattern_e pattern;
		logic [15:0] user_word;
	} command_s;
endpackage
